// *** hw/gpcn_pkg.sv ***
/*
 * Shared constants and carrier types for the parallel port with change notify.
 * Assumes a 32-bit Avalon-MM slave with word addresses given as byte offsets.
 */
package gpcn_pkg;
    localparam int GPCN_WIDTH = 16;
    localparam int GPCN_CN_NUM = 23;
    localparam logic [GPCN_WIDTH-1:0] GPCN_IMPL_MASK = 16'hFFFF;
    localparam logic [GPCN_WIDTH-1:0] GPCN_DIR_RST = 16'hFFFF;
    localparam logic [GPCN_WIDTH-1:0] GPCN_HOLD_RST = 16'h0000;
    localparam logic [15:0] GPCN_CTRL_RST = 16'h0000;

    localparam logic [5:0] GPCN_OFF_DIR = 6'h00;
    localparam logic [5:0] GPCN_OFF_PIN = 6'h04;
    localparam logic [5:0] GPCN_OFF_HOLD = 6'h08;
    localparam logic [5:0] GPCN_OFF_IRQEN_LO = 6'h0C;
    localparam logic [5:0] GPCN_OFF_IRQEN_HI = 6'h10;
    localparam logic [5:0] GPCN_OFF_PU_LO = 6'h14;
    localparam logic [5:0] GPCN_OFF_PU_HI = 6'h18;
    localparam logic [5:0] GPCN_OFF_PD_LO = 6'h1C;
    localparam logic [5:0] GPCN_OFF_PD_HI = 6'h20;
    localparam logic [5:0] GPCN_OFF_STAT = 6'h24;
    localparam logic [5:0] GPCN_OFF_CTRL = 6'h28;

    localparam int GPCN_STAT_FLAG = 0;
    localparam int GPCN_CTRL_RESTORE = 0;
    localparam int GPCN_LO_BITS = 16;
    localparam logic [31:0] GPCN_UNMAPPED = 32'h0000_0000;

    typedef struct packed {
        logic [GPCN_WIDTH-1:0] drive;
        logic [GPCN_WIDTH-1:0] oe;
    } gpcn_pad_s;

    typedef struct packed {
        logic [GPCN_WIDTH-1:0] enable;
        logic [GPCN_WIDTH-1:0] active;
        logic [GPCN_WIDTH-1:0] data;
        logic [GPCN_WIDTH-1:0] input_only;
    } gpcn_periph_s;
endpackage

// *** hw/gpcn_sync2.sv ***
/*
 * Two-flop synchroniser for a bus of asynchronous pin levels.
 * Assumes the first stage is read by the second stage only.
 */
`timescale 1ns/10ps
module gpcn_sync2 #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// *** hw/gpcn_cos_latch.sv ***
/*
 * Clockless change-of-state capture for one change notify input.
 * Assumes the pin raw level toggles the capture flop while clocks are stopped;
 * the clocked side compares a snapshot of it against its own copy.
 */
`timescale 1ns/10ps
module gpcn_cos_latch (
    input wire logic pin_raw,
    input wire logic arm,
    output logic edge_tog
);
    // toggles on either pin edge with no system clock; read only via a synchroniser
    logic rise_t;
    logic fall_t;

    always_ff @(posedge pin_raw or negedge arm) begin
        if (!arm) begin
            rise_t <= 1'b0;
        end else begin
            rise_t <= ~rise_t;
        end
    end

    always_ff @(negedge pin_raw or negedge arm) begin
        if (!arm) begin
            fall_t <= 1'b0;
        end else begin
            fall_t <= ~fall_t;
        end
    end

    assign edge_tog = rise_t ^ fall_t;
endmodule

// *** hw/gpcn_port.sv ***
/*
 * Parallel I/O port with peripheral sharing and input change notification.
 * Assumes Avalon-MM master per its spec, async pins, and software keeping
 * pull-up/pull-down and port timing rules on its own side.
 */
`timescale 1ns/10ps
module gpcn_port
    import gpcn_pkg::*;
#(
    parameter int CN_NUM = GPCN_CN_NUM
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [gpcn_pkg::GPCN_WIDTH-1:0] pin_in,
    output gpcn_pkg::gpcn_pad_s pad_out,
    input wire gpcn_pkg::gpcn_periph_s periph,
    output logic [gpcn_pkg::GPCN_WIDTH-1:0] periph_in,
    input wire logic [CN_NUM-1:0] change_detect_input,
    input wire logic deep_sleep,
    output logic [CN_NUM-1:0] weak_pullup,
    output logic [CN_NUM-1:0] weak_pulldown,
    output logic change_irq
);
    import gpcn_pkg::*;

    localparam int HI_BITS = CN_NUM - GPCN_LO_BITS;

    logic [GPCN_WIDTH-1:0] pin_direction_reg;
    logic [GPCN_WIDTH-1:0] output_hold_reg;
    logic [CN_NUM-1:0] irq_en;
    logic [CN_NUM-1:0] pu_en;
    logic [CN_NUM-1:0] pd_en;
    logic restore;
    logic flag;
    logic [GPCN_WIDTH-1:0] pin_sync;
    logic [CN_NUM-1:0] tog_sync;
    logic [CN_NUM-1:0] tog_seen;
    logic [CN_NUM-1:0] cn_tog;
    logic [CN_NUM-1:0] cn_level;
    logic [CN_NUM-1:0] cn_record;
    logic ack;
    logic wr_go;
    logic [31:0] next_rdata;
    logic [31:0] wmask;
    logic [GPCN_WIDTH-1:0] own_out;
    logic [GPCN_WIDTH-1:0] own_oe;
    logic [GPCN_WIDTH-1:0] port_out;
    logic [GPCN_WIDTH-1:0] port_oe;
    logic change_hit;
    logic cn_arm;
    logic [GPCN_WIDTH-1:0] periph_owns;

    gpcn_sync2 #(.W(GPCN_WIDTH)) u_pin_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // capture flops power up unknown; a flopped arm clears them on every reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cn_arm <= 1'b0;
        end else begin
            cn_arm <= 1'b1;
        end
    end

    // edge capture needs no clock, so a change in sleep is remembered
    for (genvar i = 0; i < CN_NUM; i++) begin : g_cos
        gpcn_cos_latch u_cos (
            .pin_raw(change_detect_input[i]),
            .arm(cn_arm),
            .edge_tog(cn_tog[i])
        );
    end

    gpcn_sync2 #(.W(CN_NUM)) u_tog_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(cn_tog),
        .sync_out(tog_sync)
    );

    gpcn_sync2 #(.W(CN_NUM)) u_lvl_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(change_detect_input),
        .sync_out(cn_level)
    );

    // one wait state: request taken on the edge where waitrequest is low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read | avs_write) & ~ack;
        end
    end
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_go = avs_write & ack;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // only enabled byte lanes touch their bits
    function automatic logic [GPCN_WIDTH-1:0] merge(input logic [GPCN_WIDTH-1:0] old, input logic [31:0] wd,
                                                   input logic [31:0] m);
        merge = (old & ~m[GPCN_WIDTH-1:0]) | (wd[GPCN_WIDTH-1:0] & m[GPCN_WIDTH-1:0]);
    endfunction

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_direction_reg <= GPCN_DIR_RST & GPCN_IMPL_MASK;
        end else if (wr_go && avs_address == GPCN_OFF_DIR) begin
            pin_direction_reg <= merge(pin_direction_reg, avs_writedata, wmask)
                                 & GPCN_IMPL_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            output_hold_reg <= GPCN_HOLD_RST;
        end else if (wr_go && (avs_address == GPCN_OFF_HOLD || avs_address == GPCN_OFF_PIN)) begin
            output_hold_reg <= merge(output_hold_reg, avs_writedata, wmask)
                               & GPCN_IMPL_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_en <= '0;
            pu_en <= '0;
            pd_en <= '0;
        end else if (wr_go) begin
            case (avs_address)
                GPCN_OFF_IRQEN_LO: irq_en[GPCN_LO_BITS-1:0] <= merge(irq_en[GPCN_LO_BITS-1:0],
                    avs_writedata, wmask);
                GPCN_OFF_IRQEN_HI: irq_en[CN_NUM-1:GPCN_LO_BITS] <= HI_BITS'(merge(
                    GPCN_WIDTH'(irq_en[CN_NUM-1:GPCN_LO_BITS]), avs_writedata, wmask));
                GPCN_OFF_PU_LO: pu_en[GPCN_LO_BITS-1:0] <= merge(pu_en[GPCN_LO_BITS-1:0],
                    avs_writedata, wmask);
                GPCN_OFF_PU_HI: pu_en[CN_NUM-1:GPCN_LO_BITS] <= HI_BITS'(merge(
                    GPCN_WIDTH'(pu_en[CN_NUM-1:GPCN_LO_BITS]), avs_writedata, wmask));
                GPCN_OFF_PD_LO: pd_en[GPCN_LO_BITS-1:0] <= merge(pd_en[GPCN_LO_BITS-1:0],
                    avs_writedata, wmask);
                GPCN_OFF_PD_HI: pd_en[CN_NUM-1:GPCN_LO_BITS] <= HI_BITS'(merge(
                    GPCN_WIDTH'(pd_en[CN_NUM-1:GPCN_LO_BITS]), avs_writedata, wmask));
                default: ;
            endcase
        end
    end
    // pulls go straight to the pad; keeping them sane is software's job
    assign weak_pullup = pu_en;
    assign weak_pulldown = pd_en;

    // restore is set by entering deep sleep; set wins over a software clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            restore <= GPCN_CTRL_RST[GPCN_CTRL_RESTORE];
        end else if (deep_sleep) begin
            restore <= 1'b1;
        end else if (wr_go && avs_address == GPCN_OFF_CTRL && avs_byteenable[0]
                     && !avs_writedata[GPCN_CTRL_RESTORE]) begin
            restore <= 1'b0;
        end
    end

    // change detect: toggles flip back with the level, so a level that came back shows no edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tog_seen <= '0;
            cn_record <= '0;
        end else begin
            tog_seen <= tog_sync;
            cn_record <= cn_level;
        end
    end
    assign change_hit = |(((tog_sync ^ tog_seen) | (cn_level ^ cn_record)) & irq_en);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag <= 1'b0;
        end else if (change_hit) begin
            flag <= 1'b1;
        end else if (wr_go && avs_address == GPCN_OFF_STAT && avs_byteenable[0]
                     && avs_writedata[GPCN_STAT_FLAG]) begin
            flag <= 1'b0;
        end
    end
    assign change_irq = flag;

    // pin ownership; input-only sharers never claim the driver
    always_comb begin
        own_oe = ~pin_direction_reg & GPCN_IMPL_MASK;
        own_out = output_hold_reg;
        for (int b = 0; b < GPCN_WIDTH; b++) begin
            if (periph.enable[b] && periph.active[b] && !periph.input_only[b]) begin
                own_oe[b] = 1'b1;
                own_out[b] = periph.data[b];
            end else if (periph.input_only[b]) begin
                own_oe[b] = ~pin_direction_reg[b] & GPCN_IMPL_MASK[b];
            end
        end
        own_oe = own_oe & GPCN_IMPL_MASK;
    end

    // pads freeze while restore is held
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port_out <= '0;
            port_oe <= '0;
        end else if (!restore) begin
            port_out <= own_out;
            port_oe <= own_oe;
        end
    end
    assign pad_out.drive = port_out;
    assign pad_out.oe = port_oe;

    // port-driven bits show the peripheral zero, not the port's own output
    // an input-only sharer never owns the driver, so it must not hear the port either
    assign periph_owns = periph.enable & periph.active & ~periph.input_only;
    assign periph_in = pin_sync & ~(port_oe & ~periph_owns);

    always_comb begin
        next_rdata = GPCN_UNMAPPED;
        case (avs_address)
            GPCN_OFF_DIR: next_rdata = 32'(pin_direction_reg & GPCN_IMPL_MASK);
            GPCN_OFF_PIN: next_rdata = 32'(pin_sync & GPCN_IMPL_MASK);
            GPCN_OFF_HOLD: next_rdata = 32'(output_hold_reg & GPCN_IMPL_MASK);
            GPCN_OFF_IRQEN_LO: next_rdata = 32'(irq_en[GPCN_LO_BITS-1:0]);
            GPCN_OFF_IRQEN_HI: next_rdata = 32'(irq_en[CN_NUM-1:GPCN_LO_BITS]);
            GPCN_OFF_PU_LO: next_rdata = 32'(pu_en[GPCN_LO_BITS-1:0]);
            GPCN_OFF_PU_HI: next_rdata = 32'(pu_en[CN_NUM-1:GPCN_LO_BITS]);
            GPCN_OFF_PD_LO: next_rdata = 32'(pd_en[GPCN_LO_BITS-1:0]);
            GPCN_OFF_PD_HI: next_rdata = 32'(pd_en[CN_NUM-1:GPCN_LO_BITS]);
            GPCN_OFF_STAT: next_rdata = 32'(flag);
            GPCN_OFF_CTRL: next_rdata = 32'(restore);
            default: next_rdata = GPCN_UNMAPPED;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_readdata <= '0;
        end else if (avs_read && !ack) begin
            avs_readdata <= next_rdata;
        end
    end

    // pin ownership and register paths
    a_dir_reset: assert property (@(posedge clk)
        $fell(sys_rst) |-> pin_direction_reg == (GPCN_DIR_RST & GPCN_IMPL_MASK))
        else $error("direction not all inputs after reset");
    a_input_no_drive: assert property (@(posedge clk) disable iff (sys_rst)
        (!restore && pin_direction_reg[0] && !periph.enable[0]) |=> !port_oe[0] || $past(restore))
        else $error("input pin driven");
    a_periph_owns: assert property (@(posedge clk) disable iff (sys_rst)
        (!restore && periph.enable[0] && periph.active[0] && !periph.input_only[0])
        |=> port_oe[0] && port_out[0] == $past(periph.data[0]))
        else $error("peripheral lost its pin");
    a_idle_periph: assert property (@(posedge clk) disable iff (sys_rst)
        (!restore && periph.enable[1] && !periph.active[1] && !pin_direction_reg[1])
        |=> port_oe[1] && port_out[1] == $past(output_hold_reg[1]))
        else $error("port not driving idle shared pin");
    a_no_loop: assert property (@(posedge clk) disable iff (sys_rst)
        (port_oe[0] && !(periph.enable[0] && periph.active[0])) |-> !periph_in[0])
        else $error("port output looped to peripheral");
    a_pin_wr_latch: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_go && avs_address == GPCN_OFF_PIN && avs_byteenable == 4'hF)
        |=> output_hold_reg == ($past(avs_writedata[GPCN_WIDTH-1:0]) & GPCN_IMPL_MASK))
        else $error("pin write missed latch");
    a_hold_write: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_go && avs_address == GPCN_OFF_HOLD && avs_byteenable == 4'hF)
        |=> output_hold_reg == ($past(avs_writedata[GPCN_WIDTH-1:0]) & GPCN_IMPL_MASK))
        else $error("latch write lost");
    a_hold_read: assert property (@(posedge clk) disable iff (sys_rst)
        (avs_read && !ack && avs_address == GPCN_OFF_HOLD) |=> avs_readdata == 32'($past(output_hold_reg)))
        else $error("latch read mismatch");
    a_pin_read: assert property (@(posedge clk) disable iff (sys_rst)
        (avs_read && !ack && avs_address == GPCN_OFF_PIN) |=> avs_readdata == 32'($past(pin_sync) & GPCN_IMPL_MASK))
        else $error("pin read mismatch");
    a_freeze_pads: assert property (@(posedge clk) disable iff (sys_rst)
        restore ##1 restore |-> $stable(port_out) && $stable(port_oe))
        else $error("pads moved while held");
    a_sleep_hold: assert property (@(posedge clk) disable iff (sys_rst)
        deep_sleep |=> restore)
        else $error("sleep did not hold pads");

    // change flag, enables and pulls
    a_change_flag: assert property (@(posedge clk) disable iff (sys_rst)
        change_hit |=> flag ##1 (flag || $past(wr_go)))
        else $error("change did not set flag");
    a_flag_cause: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(flag) |-> $past(change_hit))
        else $error("flag set without change");
    a_flag_clear: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_go && avs_address == GPCN_OFF_STAT && avs_byteenable[0] && avs_writedata[GPCN_STAT_FLAG] && !change_hit)
        |=> !flag)
        else $error("flag not cleared by software");
    a_toggle_hit: assert property (@(posedge clk) disable iff (sys_rst)
        (|((tog_sync ^ tog_seen) & irq_en)) |=> flag)
        else $error("captured edge did not set flag");
    a_irqen_lo: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_go && avs_address == GPCN_OFF_IRQEN_LO && avs_byteenable == 4'hF)
        |=> irq_en[GPCN_LO_BITS-1:0] == $past(avs_writedata[GPCN_LO_BITS-1:0]))
        else $error("low enable write lost");
    a_irqen_hi: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_go && avs_address == GPCN_OFF_IRQEN_HI && avs_byteenable == 4'hF)
        |=> irq_en[CN_NUM-1:GPCN_LO_BITS] == $past(avs_writedata[HI_BITS-1:0]))
        else $error("high enable write lost");
    a_pullup_wr: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_go && avs_address == GPCN_OFF_PU_LO && avs_byteenable == 4'hF)
        |=> weak_pullup[GPCN_LO_BITS-1:0] == $past(avs_writedata[GPCN_LO_BITS-1:0]))
        else $error("pull-up write lost");
    a_pulldown_wr: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_go && avs_address == GPCN_OFF_PD_HI && avs_byteenable == 4'hF)
        |=> weak_pulldown[CN_NUM-1:GPCN_LO_BITS] == $past(avs_writedata[HI_BITS-1:0]))
        else $error("pull-down write lost");

    c_read_pin: cover property (@(posedge clk) avs_read && ack && avs_address == GPCN_OFF_PIN);
    c_irq: cover property (@(posedge clk) $rose(change_irq));
    c_periph_take: cover property (@(posedge clk) periph.enable[0] && periph.active[0] ##1 port_oe[0]);
    c_restore_clear: cover property (@(posedge clk) $fell(restore));
    c_sleep_hold: cover property (@(posedge clk) $rose(restore));
endmodule

// *** verif/gpcn_pin_model.sv ***
/*
 * Pin side model: external drivers and push buttons on port and change pins.
 * Assumes the bench chooses which lines it drives; released lines float or pull.
 */
`timescale 1ns/10ps
module gpcn_pin_model
    import gpcn_pkg::*;
(
    input wire logic clk,
    input wire gpcn_pkg::gpcn_pad_s pad_out,
    input wire logic [gpcn_pkg::GPCN_WIDTH-1:0] ext_drv,
    input wire logic [gpcn_pkg::GPCN_WIDTH-1:0] ext_en,
    input wire logic [gpcn_pkg::GPCN_CN_NUM-1:0] cn_ext,
    input wire logic [gpcn_pkg::GPCN_CN_NUM-1:0] cn_en,
    input wire logic [gpcn_pkg::GPCN_CN_NUM-1:0] weak_pullup,
    input wire logic [gpcn_pkg::GPCN_CN_NUM-1:0] weak_pulldown,
    output logic [gpcn_pkg::GPCN_WIDTH-1:0] pin_in,
    output logic [gpcn_pkg::GPCN_CN_NUM-1:0] cn_in
);
    // a floating line wanders, so it never settles into a lucky match
    logic [GPCN_WIDTH-1:0] float_pin = '0;
    logic [GPCN_CN_NUM-1:0] float_cn = '0;
    always @(posedge clk) begin
        float_pin <= ~float_pin;
        float_cn <= ~float_cn;
    end
    assign pin_in = (pad_out.oe & pad_out.drive)
        | (~pad_out.oe & ((ext_en & ext_drv) | (~ext_en & float_pin)));
    assign cn_in = (cn_en & cn_ext) | (~cn_en & (weak_pullup | (~weak_pulldown & float_cn)));
endmodule

// *** verif/gpcn_port_tb.sv ***
/*
 * Self-checking bench for the parallel port with change notify.
 * Assumes gpcn_pin_model on the pin side and the bench as Avalon-MM master.
 */
`timescale 1ns/10ps
module gpcn_port_tb;
    import gpcn_pkg::*;
    logic clk, run_clk, sys_rst, avs_read, avs_write, avs_waitrequest, deep_sleep, change_irq;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [15:0] pin_in, periph_in, ext_drv, ext_en;
    logic [GPCN_CN_NUM-1:0] cn_in, cn_ext, cn_en, weak_pullup, weak_pulldown;
    gpcn_pad_s pad_out;
    gpcn_periph_s periph;
    int bad_count = 0;
    int n_checks = 0;

    // stoppable so change capture can be seen with no clock running
    initial begin
        clk = 1'b0;
        forever #12.5 if (run_clk) clk = ~clk;
    end

    gpcn_port i_gpcn_port (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pad_out(pad_out),
        .periph(periph), .periph_in(periph_in), .change_detect_input(cn_in), .deep_sleep(deep_sleep),
        .weak_pullup(weak_pullup), .weak_pulldown(weak_pulldown), .change_irq(change_irq));
    gpcn_pin_model i_gpcn_pin_model (.clk(clk), .pad_out(pad_out), .ext_drv(ext_drv), .ext_en(ext_en),
        .cn_ext(cn_ext), .cn_en(cn_en), .weak_pullup(weak_pullup), .weak_pulldown(weak_pulldown),
        .pin_in(pin_in), .cn_in(cn_in));

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one edge idle before each request, so no signal is driven twice at an edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wait_irq(input logic exp);
        int n;
        n = 0;
        while (change_irq !== exp && n < 8) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, change_irq}, {31'h0, exp});
    endtask

    task automatic t_reset;
        bus(1'b0, GPCN_OFF_DIR, 32'h0);
        chk(rd, {16'h0, GPCN_DIR_RST});
        chk({16'h0, pad_out.oe}, 32'h0);
        bus(1'b0, GPCN_OFF_HOLD, 32'h0);
        chk(rd, {16'h0, GPCN_HOLD_RST});
        chk({8'h0, weak_pullup | weak_pulldown, change_irq}, 32'h0);
    endtask

    task automatic t_port;
        bus(1'b1, GPCN_OFF_HOLD, 32'h0000_12C3);
        bus(1'b1, GPCN_OFF_DIR, 32'h0000_FF00);
        repeat (3) @(posedge clk);
        bus(1'b0, GPCN_OFF_HOLD, 32'h0);
        chk(rd, 32'h0000_12C3);
        chk({pad_out.oe, pad_out.drive & pad_out.oe}, 32'h00FF_00C3);
        bus(1'b0, GPCN_OFF_PIN, 32'h0);
        chk(rd, 32'h0000_5AC3);
        bus(1'b1, GPCN_OFF_PIN, 32'h0000_0F0F);
        repeat (3) @(posedge clk);
        bus(1'b0, GPCN_OFF_HOLD, 32'h0);
        chk(rd, 32'h0000_0F0F);
        bus(1'b0, GPCN_OFF_PIN, 32'h0);
        chk(rd, 32'h0000_5A0F);
    endtask

    task automatic t_refuse;
        bus(1'b1, GPCN_OFF_DIR, 32'hFFFF_FFFF);
        bus(1'b0, GPCN_OFF_DIR, 32'h0);
        chk(rd, {16'h0, GPCN_IMPL_MASK});
        bus(1'b1, 6'h2C, 32'hFFFF_FFFF);
        bus(1'b0, 6'h2C, 32'h0);
        chk(rd, GPCN_UNMAPPED);
        bus(1'b0, GPCN_OFF_HOLD, 32'h0);
        chk(rd, 32'h0000_0F0F);
    endtask

    task automatic t_share;
        bus(1'b1, GPCN_OFF_HOLD, 32'h0000_0006);
        bus(1'b1, GPCN_OFF_DIR, 32'h0000_FF00);
        periph <= '{enable: 16'h0007, active: 16'h0005, data: 16'h0001, input_only: 16'h0004};
        repeat (4) @(posedge clk);
        chk({pad_out.oe & 16'h0007, pad_out.drive & 16'h0007}, 32'h0007_0007);
        chk({16'h0, periph_in & 16'h0006}, 32'h0);
        bus(1'b0, GPCN_OFF_PIN, 32'h0);
        chk(rd & 32'h7, 32'h7);
        periph <= '0;
    endtask

    task automatic t_change;
        bus(1'b1, GPCN_OFF_IRQEN_LO, 32'h0000_0008);
        bus(1'b1, GPCN_OFF_IRQEN_HI, 32'h0000_0004);
        bus(1'b1, GPCN_OFF_STAT, 32'h1);
        bus(1'b0, GPCN_OFF_IRQEN_HI, 32'h0);
        chk(rd, 32'h4);
        cn_ext[5] <= 1'b1;
        repeat (8) @(posedge clk);
        chk({31'h0, change_irq}, 32'h0);
        cn_ext[3] <= 1'b1;
        wait_irq(1'b1);
        bus(1'b0, GPCN_OFF_STAT, 32'h0);
        chk(rd, 32'h1);
        bus(1'b1, GPCN_OFF_STAT, 32'h1);
        wait_irq(1'b0);
        @(negedge clk);
        run_clk = 1'b0;
        #100 cn_ext[18] = 1'b1;
        #200 run_clk = 1'b1;
        wait_irq(1'b1);
        bus(1'b1, GPCN_OFF_STAT, 32'h1);
        wait_irq(1'b0);
    endtask

    task automatic t_pull;
        bus(1'b1, GPCN_OFF_PU_LO, 32'h0000_0010);
        bus(1'b1, GPCN_OFF_PD_HI, 32'h0000_0002);
        cn_en <= 23'h7D_FFEF;
        repeat (2) @(posedge clk);
        chk({9'h0, weak_pullup}, 32'h0000_0010);
        chk({9'h0, weak_pulldown}, 32'h0002_0000);
        bus(1'b0, GPCN_OFF_PD_HI, 32'h0);
        chk(rd, 32'h2);
    endtask

    task automatic t_sleep;
        bus(1'b1, GPCN_OFF_HOLD, 32'h0000_00AA);
        bus(1'b1, GPCN_OFF_DIR, 32'h0000_FF00);
        deep_sleep <= 1'b1;
        repeat (3) @(posedge clk);
        deep_sleep <= 1'b0;
        bus(1'b0, GPCN_OFF_CTRL, 32'h0);
        chk(rd, 32'h1);
        bus(1'b1, GPCN_OFF_HOLD, 32'h0000_0055);
        repeat (3) @(posedge clk);
        chk({16'h0, pad_out.drive & 16'h00FF}, 32'h0000_00AA);
        bus(1'b1, GPCN_OFF_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        chk({16'h0, pad_out.drive & 16'h00FF}, 32'h0000_0055);
    endtask

    task automatic t_rereset;
        bus(1'b1, GPCN_OFF_DIR, 32'h0);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        bus(1'b0, GPCN_OFF_DIR, 32'h0);
        chk(rd, {16'h0, GPCN_DIR_RST});
        chk({16'h0, pad_out.oe}, 32'h0);
    endtask

    initial begin
        run_clk = 1'b1;
        sys_rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        deep_sleep = 1'b0;
        periph = '0;
        ext_drv = 16'h5A00;
        ext_en = 16'hFFFF;
        cn_ext = '0;
        cn_en = '1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset;
        t_port;
        t_refuse;
        t_share;
        t_change;
        t_pull;
        t_sleep;
        t_rereset;
        stop_test;
    end

    // the whole run needs well under a thousand cycles
    initial begin
        #200000;
        bad_count++;
        stop_test;
    end
endmodule
